// ==== pbgpio_defines.svh ====
`ifndef PBGPIO_DEFINES_SVH
`define PBGPIO_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PBGPIO_OFS_PORT 8'h00
`define PBGPIO_OFS_LATCH 8'h04
`define PBGPIO_OFS_DIR 8'h08
`define PBGPIO_OFS_MAIN_IRQ 8'h0C
`define PBGPIO_OFS_SECOND_IRQ 8'h10
`define PBGPIO_OFS_SEG_A 8'h14
`define PBGPIO_OFS_SEG_C 8'h18
`define PBGPIO_OFS_STATUS 8'h1C
`define PBGPIO_OFS_CLEAR 8'h20
`define PBGPIO_OFS_ENABLE 8'h24
`define PBGPIO_OFS_MOVE 8'h28

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PBGPIO_MAIN_FLAG_BIT 0
`define PBGPIO_MAIN_IRQ_EN_BIT 3
`define PBGPIO_SECOND_PU_N_BIT 7
`define PBGPIO_SECOND_PRIO_BIT 0
`define PBGPIO_EV_CHANGE_BIT 0
`define PBGPIO_EV_BADADDR_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PBGPIO_RST_DIR 8'hFF
`define PBGPIO_RST_LATCH 8'h00
`define PBGPIO_RST_MAIN_IRQ 8'h00
`define PBGPIO_RST_SECOND_IRQ 8'h80
`define PBGPIO_RST_SEG 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PBGPIO_HOLDOFF_TCY 1
`define PBGPIO_CLKS_PER_TCY 4
`define PBGPIO_HOLDOFF_CLKS (`PBGPIO_HOLDOFF_TCY * `PBGPIO_CLKS_PER_TCY)

`endif

// ==== pbgpio_pkg.sv ====
package pbgpio_pkg;

  // Per-pin drive bundle towards the pad ring
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pullup_on;
  } pbgpio_pad_t;

  // Programming/debug side of the two upper pins
  typedef struct packed {
    logic active;
    logic data_out;
    logic data_drive;
  } pbgpio_dbg_t;

  typedef logic [1:0] pbgpio_resp_t;

endpackage

// ==== pbgpio_pin_mux.sv ====
`timescale 1ns/1ps
`include "pbgpio_defines.svh"

module pbgpio_pin_mux (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Control
  input wire logic [7:0] dir,
  input wire logic [7:0] latch,
  input wire logic pullup_enable_n,
  input wire logic [7:0] seg_own,
  input wire pbgpio_pkg::pbgpio_dbg_t dbg,
  // Pad drive
  output pbgpio_pkg::pbgpio_pad_t pad
);
  import pbgpio_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      wire is_dbg_clk = (i == 6) && dbg.active;
      wire is_dbg_dat = (i == 7) && dbg.active;
      wire drive_lat = ~dir[i] & ~seg_own[i] & ~is_dbg_clk & ~is_dbg_dat;
      wire drive_on = is_dbg_dat ? dbg.data_drive : drive_lat;
      wire drive_val = is_dbg_dat ? dbg.data_out : latch[i];
      always_ff @(posedge mclk) begin
        if (srst) begin
          pad.out[i] <= 1'b0;
          pad.oe_n[i] <= 1'b1;
          pad.pullup_on[i] <= 1'b0;
        end else begin
          pad.out[i] <= drive_val;
          pad.oe_n[i] <= ~drive_on;
          pad.pullup_on[i] <= ~pullup_enable_n & dir[i] & ~seg_own[i];
        end
      end
    end
  endgenerate
endmodule

// ==== pbgpio_change_det.sv ====
`timescale 1ns/1ps
`include "pbgpio_defines.svh"

module pbgpio_change_det (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Pins and control
  input wire logic [3:0] pins_hi,
  input wire logic [3:0] watch,
  input wire logic port_access,
  // Status
  output logic [3:0] copy_reg,
  output logic mismatch,
  output logic holdoff
);
  logic [2:0] hold_cnt_reg;

  assign mismatch = |((pins_hi ^ copy_reg) & watch);
  assign holdoff = (hold_cnt_reg != 3'h0);

  always_ff @(posedge mclk) begin
    if (srst) begin
      copy_reg <= 4'h0;
      hold_cnt_reg <= 3'h0;
    end else if (port_access) begin
      copy_reg <= pins_hi;
      hold_cnt_reg <= 3'(`PBGPIO_HOLDOFF_CLKS);
    end else if (holdoff) begin
      hold_cnt_reg <= hold_cnt_reg - 3'h1;
    end
  end
endmodule

// ==== pbgpio_top.sv ====
`timescale 1ns/1ps
`include "pbgpio_defines.svh"

module pbgpio_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output pbgpio_pkg::pbgpio_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output pbgpio_pkg::pbgpio_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [7:0] pin_in,
  output pbgpio_pkg::pbgpio_pad_t pad,
  // Segment ownership of the lower six pins
  output logic [5:0] seg_override,
  // Programming and debug
  input wire pbgpio_pkg::pbgpio_dbg_t dbg,
  output logic prog_debug_clock,
  output logic prog_debug_data,
  // External interrupt inputs
  output logic [3:0] ext_irq_in,
  // Interrupts and wake
  output logic port_change_irq,
  output logic port_change_irq_priority,
  output logic wake_req,
  output logic irq
);
  import pbgpio_pkg::*;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0] port_pins_reg;
  logic [7:0] port_output_latch_reg;
  logic [7:0] port_direction_reg;
  logic [7:0] main_irq_ctrl_reg;
  logic [7:0] second_irq_ctrl_reg;
  logic [7:0] segment_enable_reg_a;
  logic [7:0] segment_enable_reg_c;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic port_change_flag;
  logic port_change_irq_en;
  logic pullup_enable_n;

  // --------------------------------------------------------------------
  // Bus slave state
  // --------------------------------------------------------------------
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic wr_strb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire wr_do = aw_got_reg & w_got_reg & ~bvalid_reg;

  assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_got_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // --------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------
  wire wr_en = wr_do & wr_strb0_reg;
  wire [7:0] wbyte = wr_data_reg[7:0];
  wire wr_port = wr_en & (wr_addr_reg == `PBGPIO_OFS_PORT);
  wire wr_latch = wr_en & (wr_addr_reg == `PBGPIO_OFS_LATCH);
  wire wr_dir = wr_en & (wr_addr_reg == `PBGPIO_OFS_DIR);
  wire wr_main = wr_en & (wr_addr_reg == `PBGPIO_OFS_MAIN_IRQ);
  wire wr_second = wr_en & (wr_addr_reg == `PBGPIO_OFS_SECOND_IRQ);
  wire wr_seg_a = wr_en & (wr_addr_reg == `PBGPIO_OFS_SEG_A);
  wire wr_seg_c = wr_en & (wr_addr_reg == `PBGPIO_OFS_SEG_C);
  wire wr_clear = wr_en & (wr_addr_reg == `PBGPIO_OFS_CLEAR);
  wire wr_enable = wr_en & (wr_addr_reg == `PBGPIO_OFS_ENABLE);
  wire wr_move = wr_en & (wr_addr_reg == `PBGPIO_OFS_MOVE);
  wire wr_mapped = (wr_addr_reg == `PBGPIO_OFS_PORT)
                 | (wr_addr_reg == `PBGPIO_OFS_LATCH)
                 | (wr_addr_reg == `PBGPIO_OFS_DIR)
                 | (wr_addr_reg == `PBGPIO_OFS_MAIN_IRQ)
                 | (wr_addr_reg == `PBGPIO_OFS_SECOND_IRQ)
                 | (wr_addr_reg == `PBGPIO_OFS_SEG_A)
                 | (wr_addr_reg == `PBGPIO_OFS_SEG_C)
                 | (wr_addr_reg == `PBGPIO_OFS_CLEAR)
                 | (wr_addr_reg == `PBGPIO_OFS_ENABLE)
                 | (wr_addr_reg == `PBGPIO_OFS_MOVE);

  // --------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------
  wire [7:0] ra = s_axi_araddr;
  wire rd_port = ar_hs & (ra == `PBGPIO_OFS_PORT);
  wire rd_mapped = (ra == `PBGPIO_OFS_PORT) | (ra == `PBGPIO_OFS_LATCH)
                 | (ra == `PBGPIO_OFS_DIR) | (ra == `PBGPIO_OFS_MAIN_IRQ)
                 | (ra == `PBGPIO_OFS_SECOND_IRQ)
                 | (ra == `PBGPIO_OFS_SEG_A) | (ra == `PBGPIO_OFS_SEG_C)
                 | (ra == `PBGPIO_OFS_STATUS) | (ra == `PBGPIO_OFS_ENABLE);
  wire [7:0] rd_byte =
      (ra == `PBGPIO_OFS_PORT) ? port_pins_reg :
      (ra == `PBGPIO_OFS_LATCH) ? port_output_latch_reg :
      (ra == `PBGPIO_OFS_DIR) ? port_direction_reg :
      (ra == `PBGPIO_OFS_MAIN_IRQ) ? main_irq_ctrl_reg :
      (ra == `PBGPIO_OFS_SECOND_IRQ) ? second_irq_ctrl_reg :
      (ra == `PBGPIO_OFS_SEG_A) ? segment_enable_reg_a :
      (ra == `PBGPIO_OFS_SEG_C) ? segment_enable_reg_c :
      (ra == `PBGPIO_OFS_STATUS) ? {6'h00, irq_status_reg} :
      (ra == `PBGPIO_OFS_ENABLE) ? {6'h00, irq_enable_reg} : 8'h00;

  // --------------------------------------------------------------------
  // Pin function selection
  // --------------------------------------------------------------------
  wire [7:0] seg_own = {2'b00, seg_override};
  assign seg_override = {segment_enable_reg_c[5],
                         segment_enable_reg_a[3:0],
                         segment_enable_reg_c[6]};
  assign pullup_enable_n = second_irq_ctrl_reg[`PBGPIO_SECOND_PU_N_BIT];
  assign port_change_flag = main_irq_ctrl_reg[`PBGPIO_MAIN_FLAG_BIT];
  assign port_change_irq_en = main_irq_ctrl_reg[`PBGPIO_MAIN_IRQ_EN_BIT];
  assign port_change_irq_priority =
      second_irq_ctrl_reg[`PBGPIO_SECOND_PRIO_BIT];

  // Debug pins follow the pad, whatever the direction bits say
  assign prog_debug_clock = port_pins_reg[6];
  assign prog_debug_data = port_pins_reg[7];
  assign ext_irq_in = port_pins_reg[3:0] & port_direction_reg[3:0]
                    & ~seg_own[3:0];

  pbgpio_pin_mux u_pin_mux (
    .mclk(mclk),
    .srst(srst),
    .dir(port_direction_reg),
    .latch(port_output_latch_reg),
    .pullup_enable_n(pullup_enable_n),
    .seg_own(seg_own),
    .dbg(dbg),
    .pad(pad)
  );

  // --------------------------------------------------------------------
  // Change detection
  // --------------------------------------------------------------------
  logic [3:0] copy_reg;
  logic mismatch;
  logic holdoff;
  // The move alias writes the latch but must leave the copy alone
  wire port_access = rd_port | wr_port;
  wire [3:0] watch = port_direction_reg[7:4] & ~seg_own[7:4];

  pbgpio_change_det u_change_det (
    .mclk(mclk),
    .srst(srst),
    .pins_hi(port_pins_reg[7:4]),
    .watch(watch),
    .port_access(port_access),
    .copy_reg(copy_reg),
    .mismatch(mismatch),
    .holdoff(holdoff)
  );

  // Set wins over clear; a clear in the hold-off window is dropped
  wire flag_keep = wr_main ? (holdoff ? port_change_flag | wbyte[0]
                                      : wbyte[0])
                           : port_change_flag;
  wire flag_next = mismatch | flag_keep;
  wire [7:0] main_next = wr_main ? {wbyte[7:1], flag_next}
                                 : {main_irq_ctrl_reg[7:1], flag_next};

  assign port_change_irq = port_change_flag & port_change_irq_en;
  // Level, so it also holds a sleeping core awake until serviced
  assign wake_req = port_change_irq;

  // --------------------------------------------------------------------
  // Sticky status and interrupt
  // --------------------------------------------------------------------
  wire [1:0] events = {wr_do & ~wr_mapped, mismatch & ~port_change_flag};
  wire [1:0] status_clr = wr_clear ? wbyte[1:0] : 2'b00;
  wire [1:0] status_next = (irq_status_reg & ~status_clr) | events;
  assign irq = |(irq_status_reg & irq_enable_reg);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      port_pins_reg <= 8'h00;
      port_output_latch_reg <= `PBGPIO_RST_LATCH;
      port_direction_reg <= `PBGPIO_RST_DIR;
      main_irq_ctrl_reg <= `PBGPIO_RST_MAIN_IRQ;
      second_irq_ctrl_reg <= `PBGPIO_RST_SECOND_IRQ;
      segment_enable_reg_a <= `PBGPIO_RST_SEG;
      segment_enable_reg_c <= `PBGPIO_RST_SEG;
      irq_status_reg <= 2'b00;
      irq_enable_reg <= 2'b00;
    end else begin
      port_pins_reg <= pin_in;
      if (wr_port | wr_latch | wr_move)
        port_output_latch_reg <= wbyte;
      if (wr_dir)
        port_direction_reg <= wbyte;
      main_irq_ctrl_reg <= main_next;
      if (wr_second)
        second_irq_ctrl_reg <= wbyte;
      if (wr_seg_a)
        segment_enable_reg_a <= wbyte;
      if (wr_seg_c)
        segment_enable_reg_c <= wbyte;
      irq_status_reg <= status_next;
      if (wr_enable)
        irq_enable_reg <= wbyte[1:0];
    end
  end

  // --------------------------------------------------------------------
  // Bus handshakes
  // --------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 32'h0000_0000;
      wr_strb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
    end else begin
      if (aw_hs) begin
        aw_got_reg <= 1'b1;
        wr_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_hs) begin
        w_got_reg <= 1'b1;
        wr_data_reg <= s_axi_wdata;
        wr_strb0_reg <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? 2'b00 : 2'b10;
      end else if (bvalid_reg & s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'b00;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_mapped ? 2'b00 : 2'b10;
    end else if (rvalid_reg & s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence s_clear_in_holdoff;
    wr_main & ~wbyte[0] & holdoff & port_change_flag;
  endsequence

  sequence s_clear_free;
    wr_main & ~wbyte[0] & ~holdoff & ~mismatch;
  endsequence

  property p_pullup_output_off;
    @(posedge mclk) disable iff (srst)
      ~port_direction_reg[0] |=> ~pad.pullup_on[0];
  endproperty
  a_pullup_output_off: assert property (p_pullup_output_off)
    else $error("pull-up left on for an output pin");

  property p_reset_pullups_off;
    @(posedge mclk) $past(srst) & ~wr_second |->
      second_irq_ctrl_reg[7] ##1 pad.pullup_on == 8'h00;
  endproperty
  a_reset_pullups_off: assert property (p_reset_pullups_off)
    else $error("pull-ups not disabled after reset");

  property p_mismatch_sets_flag;
    @(posedge mclk) disable iff (srst)
      mismatch |=> port_change_flag;
  endproperty
  a_mismatch_sets_flag: assert property (p_mismatch_sets_flag)
    else $error("mismatch did not set the change flag");

  property p_flag_rise_cause;
    @(posedge mclk) disable iff (srst)
      $rose(port_change_flag) |-> $past(mismatch) | $past(wr_main);
  endproperty
  a_flag_rise_cause: assert property (p_flag_rise_cause)
    else $error("change flag rose without a cause");

  property p_read_refreshes_copy;
    @(posedge mclk) disable iff (srst)
      rd_port |=> copy_reg == $past(port_pins_reg[7:4]);
  endproperty
  a_read_refreshes_copy: assert property (p_read_refreshes_copy)
    else $error("port read did not refresh the copy");

  property p_move_keeps_copy;
    @(posedge mclk) disable iff (srst)
      wr_move & ~rd_port |=> $stable(copy_reg);
  endproperty
  a_move_keeps_copy: assert property (p_move_keeps_copy)
    else $error("move into the port refreshed the copy");

  property p_holdoff_blocks_clear;
    @(posedge mclk) disable iff (srst)
      s_clear_in_holdoff |=> port_change_flag;
  endproperty
  a_holdoff_blocks_clear: assert property (p_holdoff_blocks_clear)
    else $error("flag cleared inside the hold-off window");

  property p_clear_after_holdoff;
    @(posedge mclk) disable iff (srst)
      s_clear_free |=> ~port_change_flag;
  endproperty
  a_clear_after_holdoff: assert property (p_clear_after_holdoff)
    else $error("flag clear ignored after hold-off");

  property p_segment_override;
    @(posedge mclk) disable iff (srst)
      seg_override[1] |=> pad.oe_n[1];
  endproperty
  a_segment_override: assert property (p_segment_override)
    else $error("port drove a pin owned by a segment");

  property p_wake;
    @(posedge mclk) disable iff (srst)
      port_change_flag & port_change_irq_en |-> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("change interrupt did not request wake");
endmodule

// ==== pbgpio_board.sv ====
`timescale 1ns/1ps

module pbgpio_board (
  // Clock
  input wire logic mclk,
  // Device pad drive
  input wire pbgpio_pkg::pbgpio_pad_t pad,
  // Board switches and keys
  input wire logic [7:0] drv_en,
  input wire logic [7:0] drv_val,
  // Resolved pin levels
  output logic [7:0] pin_in
);
  import pbgpio_pkg::*;
  logic [7:0] float_reg = 8'h00;
  logic [7:0] dev_drv;
  logic [7:0] brd_drv;
  logic [7:0] pulled;
  logic [7:0] floating;

  // ----------------------------------------------------------------
  // Line resolution
  // ----------------------------------------------------------------
  // Unpulled open lines wander so a stale level never passes
  always_ff @(posedge mclk) begin
    float_reg <= ~float_reg;
  end
  assign dev_drv = ~pad.oe_n & pad.out;
  assign brd_drv = pad.oe_n & drv_en & drv_val;
  assign pulled = pad.oe_n & ~drv_en & pad.pullup_on;
  assign floating = pad.oe_n & ~drv_en & ~pad.pullup_on & float_reg;
  assign pin_in = dev_drv | brd_drv | pulled | floating;
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps

module tb;
  import pbgpio_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  pbgpio_resp_t s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  pbgpio_resp_t s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [7:0] pin_in;
  pbgpio_pad_t pad;
  logic [5:0] seg_override;
  pbgpio_dbg_t dbg = 3'b000;
  logic prog_debug_clock, prog_debug_data, port_change_irq;
  logic port_change_irq_priority, wake_req, irq;
  logic [3:0] ext_irq_in;
  logic [7:0] drv_en = 8'hCF;
  logic [7:0] drv_val = 8'hCA;
  int n_errors = 0;
  int tests_run = 0;
  int k;

  always #20 mclk = ~mclk;

  pbgpio_top u_dut (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pad,
    .seg_override, .dbg, .prog_debug_clock, .prog_debug_data,
    .ext_irq_in, .port_change_irq, .port_change_irq_priority,
    .wake_req, .irq);

  pbgpio_board u_board (.mclk, .pad, .drv_en, .drv_val, .pin_in);

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic hung();
    n_errors++;
    $display("ERROR handshake expected answer seen none");
    test_done();
  endtask

  // Sampling right after the edge sees pre-edge values of the slave
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int i;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 40) hung();
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    int i;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 40) hung();
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h0, ed}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(2);
    srst <= 1'b0;
    rd(8'h08, 8'hFF, 2'b00);
    rd(8'h10, 8'h80, 2'b00);
    rd(8'h04, 8'h00, 2'b00);
    chk("pullup_on", 8'h00, pad.pullup_on);
    chk("oe_n", 8'hFF, pad.oe_n);
    wr(8'h04, 8'h30, 2'b00);
    wr(8'h08, 8'hCF, 2'b00);
    cyc(2);
    chk("oe_n", 8'hCF, pad.oe_n);
    chk("out", 2'b11, pad.out[5:4]);
    wr(8'h10, 8'h00, 2'b00);
    cyc(2);
    chk("pullup_on", 8'hCF, pad.pullup_on);
    drv_en <= 8'h0F;
    cyc(2);
    rd(8'h00, 8'hFA, 2'b00);
    wr(8'h00, 8'h20, 2'b00);
    rd(8'h04, 8'h20, 2'b00);
    chk("ext_irq_in", 4'hA, ext_irq_in);
    // Waiting out the hold-off before clearing is software's duty
    cyc(6);
    wr(8'h0C, 8'h08, 2'b00);
    wr(8'h24, 8'h01, 2'b00);
    wr(8'h20, 8'h03, 2'b00);
    rd(8'h0C, 8'h08, 2'b00);
    chk("irq", 1'b0, irq);
    // Key press on an upper input pin; no port polling meanwhile
    drv_en <= 8'h8F;
    drv_val <= 8'h0A;
    cyc(3);
    chk("change_irq", 1'b1, port_change_irq);
    chk("wake_req", 1'b1, wake_req);
    chk("irq", 1'b1, irq);
    wr(8'h0C, 8'h08, 2'b00);
    rd(8'h0C, 8'h09, 2'b00);
    rd(8'h1C, 8'h01, 2'b00);
    wr(8'h28, 8'h20, 2'b00);
    cyc(6);
    wr(8'h0C, 8'h08, 2'b00);
    rd(8'h0C, 8'h09, 2'b00);
    rd(8'h00, 8'h6A, 2'b00);
    // A clear this soon after the port access must be ignored
    wr(8'h0C, 8'h08, 2'b00);
    rd(8'h0C, 8'h09, 2'b00);
    cyc(6);
    wr(8'h0C, 8'h08, 2'b00);
    rd(8'h0C, 8'h08, 2'b00);
    wr(8'h20, 8'h01, 2'b00);
    cyc(2);
    chk("irq", 1'b0, irq);
    wr(8'h04, 8'h00, 2'b00);
    cyc(4);
    rd(8'h0C, 8'h08, 2'b00);
    wr(8'h3C, 8'h00, 2'b10);
    rd(8'h1C, 8'h02, 2'b00);
    chk("irq masked", 1'b0, irq);
    wr(8'h24, 8'h03, 2'b00);
    cyc(2);
    chk("irq", 1'b1, irq);
    wr(8'h20, 8'h02, 2'b00);
    rd(8'h1C, 8'h00, 2'b00);
    rd(8'h3C, 8'h00, 2'b10);
    for (k = 0; k < 4; k++) begin
      wr(8'h14, 8'h01 << k, 2'b00);
      chk("seg_override", 6'h02 << k, seg_override);
      chk("ext_irq_in", 4'hA & ~(4'h2 << k), ext_irq_in);
    end
    wr(8'h14, 8'h00, 2'b00);
    wr(8'h18, 8'h40, 2'b00);
    chk("seg_override", 6'h01, seg_override);
    wr(8'h18, 8'h20, 2'b00);
    chk("seg_override", 6'h20, seg_override);
    wr(8'h18, 8'h00, 2'b00);
    dbg <= 3'b111;
    drv_en <= 8'h4F;
    drv_val <= 8'h0A;
    cyc(3);
    chk("dbg_clock", 1'b0, prog_debug_clock);
    chk("dbg_oe_n", 1'b0, pad.oe_n[7]);
    chk("dbg_out", 1'b1, pad.out[7]);
    chk("dbg_data", 1'b1, prog_debug_data);
    wr(8'h10, 8'h81, 2'b00);
    cyc(2);
    chk("priority", 1'b1, port_change_irq_priority);
    chk("pullup_on", 8'h00, pad.pullup_on);
    // Byte lane 0 disabled: the write is answered but has no effect
    s_axi_wstrb <= 4'hE;
    wr(8'h04, 8'hFF, 2'b00);
    s_axi_wstrb <= 4'hF;
    rd(8'h04, 8'h00, 2'b00);
    test_done();
  end
endmodule
